// ===== hw/cbtf_pkg.sv
// Package: register map, field layout and constants of the CAN timing slice
package cbtf_pkg;
    // Register offsets (indices, byte address is four times the index)
    localparam logic [3:0] OFS_INT_ENABLE = 4'h0;
    localparam logic [3:0] OFS_ERR_COUNT = 4'h1;
    localparam logic [3:0] OFS_CFG_ONE = 4'h2;
    localparam logic [3:0] OFS_CFG_TWO = 4'h3;
    localparam logic [3:0] OFS_FILT_EN = 4'h4;
    localparam logic [3:0] OFS_PNT_0 = 4'h5;
    localparam logic [3:0] OFS_PNT_3 = 4'h8;
    localparam logic [3:0] OFS_INT_FLAG = 4'h9;
    localparam logic [3:0] OFS_MODE = 4'hA;
    localparam logic [3:0] OFS_TIMING = 4'hB;
    // Field masks and reset values
    localparam logic [15:0] INTE_MASK = 16'h00EF;
    localparam logic [15:0] CFG1_MASK = 16'h00FF;
    localparam logic [15:0] CFG2_MASK = 16'h47FF;
    localparam logic [15:0] FLAG_MASK = 16'h00EF;
    localparam logic [15:0] FEN_RESET = 16'hFFFF;
    localparam logic [15:0] PNT_RESET = 16'h0000;
    localparam logic [15:0] CFG2_RESET = 16'h0000;
    localparam int CFG2_WAKEUP_LINE_FILTER_SEL_BIT = 14;
    localparam int CFG2_SEG2SEL_BIT = 7;
    localparam int CFG2_SAM_BIT = 6;
    localparam int FLAG_ERR_BIT = 5;
    localparam logic [3:0] DEST_FIFO = 4'hF;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    localparam logic [2:0] MODE_RESET = 3'h4;
    localparam logic [3:0] IPT_TQ = 4'h2;
    // Decoded bit timing handed to the protocol engine
    typedef struct packed {
        logic [7:0] tq_clocks; // Up to 128 clocks, needs eight bits
        logic [2:0] sjw_tq;
        logic [3:0] prop_tq;
        logic [3:0] ph1_tq;
        logic [3:0] ph2_tq;
        logic triple_sample;
        logic wake_filter;
    } cbtf_timing_t;
    // Filter hit from the acceptance logic
    typedef struct packed {
        logic valid;
        logic [3:0] index;
    } cbtf_hit_t;
    // Routed destination of a hit
    typedef struct packed {
        logic valid;
        logic to_fifo;
        logic [3:0] buffer;
    } cbtf_route_t;
endpackage

// ===== hw/cbtf_top.sv
// CAN bit timing, error count, filter enable and routing register slice
//
// Behaviour
// - Interrupt enables in low byte bits 7,6,5,3,2,1,0; reset zero.
// - Read-only register: tx error count high byte, rx count low byte.
// - Jump width equals field plus one quanta, one to four.
// - Time quantum is two times (prescaler plus one) module clocks.
// - Phase segment two field bits 10-8 gives field plus one quanta.
// - Segment two select: programmed, else max of segment one and INFO_PROCESSING_TIME.
// - Sampling select chooses three samples or one at sample point.
// - Phase segment one field bits 5-3 gives field plus one quanta.
// - Propagation field bits 2-0 gives field plus one quanta.
// - Wake-up filter select routes wake detection through line filter.
// - Sixteen filter enables; disabled filter accepts nothing; reset all ones.
// - Pointer 1111 routes hit to FIFO, else to that numbered buffer.
// - Four pointer registers, four filters each, high filter in top nibble.
// - Unimplemented bits ignore writes and read zero.
// - Second timing register has no defined reset value.
// - Enable pairs with flag at same bit; flags cleared by software.
// - Error flag set from bus-off, passive and warning states.
// - Configuration mode is reported as mode code 100.
`timescale 1ns/1ns
module cbtf_top (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    // Register port
    input wire logic [3:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    // Protocol engine status
    input wire logic [7:0] TX_ERR_CNT_I,
    input wire logic [7:0] RX_ERR_CNT_I,
    input wire logic [5:0] ERR_STATE_I,
    input wire logic [7:0] EVENT_I,
    input wire logic [2:0] MODE_I,
    // Bus wake-up activity
    input wire logic BUS_ACT_RAW_I,
    input wire logic BUS_ACT_FILT_I,
    // Filter hit routing
    input wire cbtf_pkg::cbtf_hit_t HIT_I,
    output cbtf_pkg::cbtf_route_t ROUTE_O,
    // Timing and status outputs
    output cbtf_pkg::cbtf_timing_t TIMING_O,
    output logic TQ_TICK_O,
    output logic WAKE_ACT_O,
    output logic CONFIG_MODE_O,
    output logic IRQ_O
);

    logic [15:0] inte_q;
    logic [15:0] cfg1_q;
    logic [15:0] cfg2_q;
    logic [15:0] fen_q;
    logic [15:0] pnt_q [4];
    logic [15:0] flag_q;
    logic [15:0] errcnt_q;
    logic [2:0] mode_q;
    logic [5:0] estate_q;
    logic [7:0] event_q;
    logic act_raw_m, act_raw_q;
    logic act_filt_m, act_filt_q;
    logic [6:0] presc_cnt_q;
    cbtf_pkg::cbtf_timing_t timing_d;
    logic [3:0] dst;

    // Pointer nibble of the filter that hit
    assign dst = dest_of(HIT_I.index, pnt_q[HIT_I.index[3:2]]);

    // Selects the pointer nibble of one filter
    function automatic logic [3:0] dest_of(input logic [3:0] idx,
                                           input logic [15:0] word);
        dest_of = word[idx[1:0]*4 +: 4];
    endfunction

    // Software write to a given register index
    function automatic logic wr_hit(input logic [3:0] ofs,
                                    input logic we,
                                    input logic [3:0] addr);
        wr_hit = we && (addr == ofs);
    endfunction

    // Interrupt enable register
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            inte_q <= 16'h0000;
        else if (wr_hit(cbtf_pkg::OFS_INT_ENABLE, WR_I, ADDR_I))
            inte_q <= WDATA_I & cbtf_pkg::INTE_MASK;
    end

    // Bit timing configuration one
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            cfg1_q <= 16'h0000;
        else if (wr_hit(cbtf_pkg::OFS_CFG_ONE, WR_I, ADDR_I))
            cfg1_q <= WDATA_I & cbtf_pkg::CFG1_MASK;
    end

    // Bit timing configuration two, no reset value by design
    always_ff @(posedge CLOCK_I)
    begin
        if (wr_hit(cbtf_pkg::OFS_CFG_TWO, WR_I, ADDR_I))
            cfg2_q <= WDATA_I & cbtf_pkg::CFG2_MASK;
    end

    // Acceptance filter enables
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            fen_q <= cbtf_pkg::FEN_RESET;
        else if (wr_hit(cbtf_pkg::OFS_FILT_EN, WR_I, ADDR_I))
            fen_q <= WDATA_I;
    end

    // Buffer pointer registers, four filters each
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_pnt
            always_ff @(posedge CLOCK_I)
            begin
                if (SRST_I)
                    pnt_q[g] <= cbtf_pkg::PNT_RESET;
                else if (wr_hit(4'(cbtf_pkg::OFS_PNT_0 + g), WR_I, ADDR_I))
                    pnt_q[g] <= WDATA_I;
            end
        end
    endgenerate

    // Engine status sampled on the same clock
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            errcnt_q <= 16'h0000;
            mode_q <= cbtf_pkg::MODE_RESET;
            estate_q <= 6'h00;
            event_q <= 8'h00;
        end
        else
        begin
            errcnt_q <= {TX_ERR_CNT_I, RX_ERR_CNT_I};
            mode_q <= MODE_I;
            estate_q <= ERR_STATE_I;
            event_q <= EVENT_I;
        end
    end

    // Interrupt flags: hardware set wins over software clear
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            flag_q <= 16'h0000;
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (!cbtf_pkg::FLAG_MASK[i])
                    flag_q[i] <= 1'b0;
                else if (event_q[i] || (i == cbtf_pkg::FLAG_ERR_BIT &&
                         estate_q != 6'h00))
                    flag_q[i] <= 1'b1;
                else if (wr_hit(cbtf_pkg::OFS_INT_FLAG, WR_I, ADDR_I) &&
                         !WDATA_I[i])
                    flag_q[i] <= 1'b0;
            end
            flag_q[15:8] <= {2'b00, estate_q};
        end
    end

    // Interrupt request from enabled flags
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= |(flag_q[7:0] & inte_q[7:0]);
    end

    // Bus activity pins pass two flops
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            act_raw_m <= 1'b0;
            act_raw_q <= 1'b0;
            act_filt_m <= 1'b0;
            act_filt_q <= 1'b0;
        end
        else
        begin
            act_raw_m <= BUS_ACT_RAW_I;
            act_raw_q <= act_raw_m;
            act_filt_m <= BUS_ACT_FILT_I;
            act_filt_q <= act_filt_m;
        end
    end

    // Wake-up detection source select
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            WAKE_ACT_O <= 1'b0;
        else if (cfg2_q[cbtf_pkg::CFG2_WAKEUP_LINE_FILTER_SEL_BIT])
            WAKE_ACT_O <= act_filt_q;
        else
            WAKE_ACT_O <= act_raw_q;
    end

    // Decoded timing: quantum length in clocks, segment lengths in quanta
    always_comb
    begin
        logic [3:0] ph1;
        logic [3:0] ipt_or;
        ph1 = {1'b0, cfg2_q[5:3]} + 4'h1;
        ipt_or = (ph1 > cbtf_pkg::IPT_TQ) ? ph1 : cbtf_pkg::IPT_TQ;
        timing_d.tq_clocks = {1'b0, cfg1_q[5:0], 1'b0} + 8'h02;
        timing_d.sjw_tq = {1'b0, cfg1_q[7:6]} + 3'h1;
        timing_d.prop_tq = {1'b0, cfg2_q[2:0]} + 4'h1;
        timing_d.ph1_tq = ph1;
        timing_d.ph2_tq = cfg2_q[cbtf_pkg::CFG2_SEG2SEL_BIT] ?
            ({1'b0, cfg2_q[10:8]} + 4'h1) : ipt_or;
        timing_d.triple_sample = cfg2_q[cbtf_pkg::CFG2_SAM_BIT];
        timing_d.wake_filter = cfg2_q[cbtf_pkg::CFG2_WAKEUP_LINE_FILTER_SEL_BIT];
    end

    // Registered timing to the engine
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            TIMING_O <= '0;
        else
            TIMING_O <= timing_d;
    end

    // Time quantum prescaler, one tick per quantum
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            presc_cnt_q <= 7'h00;
            TQ_TICK_O <= 1'b0;
        end
        else if ({1'b0, presc_cnt_q} + 8'h01 >= timing_d.tq_clocks)
        begin
            presc_cnt_q <= 7'h00;
            TQ_TICK_O <= 1'b1;
        end
        else
        begin
            presc_cnt_q <= presc_cnt_q + 7'h01;
            TQ_TICK_O <= 1'b0;
        end
    end

    // Hit routing: disabled filters drop, 1111 goes to FIFO
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            ROUTE_O <= '0;
        else
        begin
            ROUTE_O.valid <= HIT_I.valid && fen_q[HIT_I.index];
            ROUTE_O.to_fifo <= (dst == cbtf_pkg::DEST_FIFO);
            ROUTE_O.buffer <= dst;
        end
    end

    // Configuration mode indication
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            CONFIG_MODE_O <= 1'b1;
        else
            CONFIG_MODE_O <= (mode_q == cbtf_pkg::MODE_CONFIG);
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I || !RD_I)
            RDATA_O <= 16'h0000;
        else
        begin
            unique case (ADDR_I)
                cbtf_pkg::OFS_INT_ENABLE: RDATA_O <= inte_q;
                cbtf_pkg::OFS_ERR_COUNT: RDATA_O <= errcnt_q;
                cbtf_pkg::OFS_CFG_ONE: RDATA_O <= cfg1_q;
                cbtf_pkg::OFS_CFG_TWO: RDATA_O <= cfg2_q;
                cbtf_pkg::OFS_FILT_EN: RDATA_O <= fen_q;
                4'h5, 4'h6, 4'h7, cbtf_pkg::OFS_PNT_3:
                    RDATA_O <= pnt_q[2'(ADDR_I - cbtf_pkg::OFS_PNT_0)];
                cbtf_pkg::OFS_INT_FLAG: RDATA_O <= flag_q;
                cbtf_pkg::OFS_MODE: RDATA_O <= {13'h0000, mode_q};
                cbtf_pkg::OFS_TIMING:
                    RDATA_O <= {8'h00, timing_d.tq_clocks};
                default: RDATA_O <= 16'h0000;
            endcase
        end
    end

endmodule

// ===== tb/cbtf_assertions.sv
// Checker: port-level properties of the CAN timing register slice
`timescale 1ns/1ns
module cbtf_chk (
    // Clock, reset and register port
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    // Status, routing and timing
    input wire logic [7:0] TX_ERR_CNT_I,
    input wire logic [7:0] RX_ERR_CNT_I,
    input wire logic [2:0] MODE_I,
    input wire cbtf_pkg::cbtf_hit_t HIT_I,
    input wire cbtf_pkg::cbtf_route_t ROUTE_O,
    input wire cbtf_pkg::cbtf_timing_t TIMING_O,
    input wire logic CONFIG_MODE_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    logic [15:0] c1_q, c2_q, fen_q;
    logic [63:0] pnt_q;
    logic [1:0] age_q;
    logic v2_q, ev_q, ef_q;
    logic [3:0] eb_q, ph1;
    assign ph1 = {1'b0, c2_q[5:3]} + 4'h1;
    // Shadow copies of written settings
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            c1_q <= 16'h0000;
            fen_q <= 16'hFFFF;
            pnt_q <= 64'h0;
        end
        else if (WR_I)
        begin
            case (ADDR_I)
                4'h2: c1_q <= WDATA_I;
                4'h3: c2_q <= WDATA_I;
                4'h4: fen_q <= WDATA_I;
                4'h5: pnt_q[15:0] <= WDATA_I;
                4'h6: pnt_q[31:16] <= WDATA_I;
                4'h7: pnt_q[47:32] <= WDATA_I;
                4'h8: pnt_q[63:48] <= WDATA_I;
                default: ;
            endcase
        end
    end
    // Cycles since the last timing write
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I || (WR_I && ADDR_I inside {4'h2, 4'h3}))
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
        v2_q <= !SRST_I && (v2_q || (WR_I && ADDR_I == 4'h3));
    end
    // Expected route of the current hit
    always_ff @(posedge CLOCK_I)
    begin
        ev_q <= fen_q[HIT_I.index];
        eb_q <= pnt_q[{HIT_I.index, 2'b00} +: 4];
        ef_q <= pnt_q[{HIT_I.index, 2'b00} +: 4] == 4'hF;
    end
    sequence rd_at(a);
        RD_I && ADDR_I == a;
    endsequence
    sequence settled;
        age_q == 2'h3 && v2_q;
    endsequence
    AST_ERR_COUNT: assert property (rd_at(4'h1) |=>
        RDATA_O == {$past(TX_ERR_CNT_I, 2), $past(RX_ERR_CNT_I, 2)})
        else $error("error count readback wrong");
    AST_INTE_RSVD: assert property (rd_at(4'h0) |=>
        (RDATA_O & ~cbtf_pkg::INTE_MASK) == 16'h0000)
        else $error("enable reserved bits set");
    AST_SJW: assert property (settled |->
        TIMING_O.sjw_tq == {1'b0, c1_q[7:6]} + 3'h1)
        else $error("jump width wrong");
    AST_TQ_LEN: assert property (settled |->
        TIMING_O.tq_clocks == {1'b0, c1_q[5:0], 1'b0} + 8'h02)
        else $error("quantum length wrong");
    AST_SEGS: assert property (settled |-> TIMING_O.ph1_tq == ph1 &&
        TIMING_O.prop_tq == {1'b0, c2_q[2:0]} + 4'h1)
        else $error("segment length wrong");
    AST_PH2: assert property (settled |-> TIMING_O.ph2_tq ==
        (c2_q[7] ? {1'b0, c2_q[10:8]} + 4'h1 :
        (ph1 > cbtf_pkg::IPT_TQ ? ph1 : cbtf_pkg::IPT_TQ)))
        else $error("phase two length wrong");
    AST_SAMPLE_WAKE: assert property (settled |->
        TIMING_O.triple_sample == c2_q[6] && TIMING_O.wake_filter == c2_q[14])
        else $error("sample or wake select wrong");
    AST_ROUTE: assert property (HIT_I.valid |=>
        ROUTE_O.valid == ev_q && (!ev_q || (ROUTE_O.to_fifo == ef_q &&
        (ef_q || ROUTE_O.buffer == eb_q))))
        else $error("hit routed wrongly");
    AST_CONFIG: assert property (!$past(SRST_I) && !$past(SRST_I, 2) |->
        CONFIG_MODE_O == ($past(MODE_I, 2) == cbtf_pkg::MODE_CONFIG))
        else $error("configuration mode flag wrong");
endmodule
bind cbtf_top cbtf_chk u_cbtf_chk (.CLOCK_I, .SRST_I, .ADDR_I, .WDATA_I,
    .WR_I, .RD_I, .RDATA_O, .TX_ERR_CNT_I, .RX_ERR_CNT_I, .MODE_I, .HIT_I,
    .ROUTE_O, .TIMING_O, .CONFIG_MODE_O);

// ===== tb/cbtf_node_model.sv
// Partner: remote node making activity on the shared bus line
`timescale 1ns/1ns
module cbtf_node_model (
    // Clock and command
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [3:0] len_i,
    // Activity seen raw and after the line filter
    output logic raw_o,
    output logic filt_o
);
    logic [3:0] left_q;
    logic [1:0] run_q;
    assign raw_o = left_q != 4'h0;
    // Dominant run of len_i cycles, idle otherwise
    always @(posedge clk_i)
    begin
        left_q <= go_i ? len_i : left_q - {3'h0, raw_o};
        run_q <= raw_o ? run_q + {1'b0, run_q != 2'h3} : 2'h0;
    end
    // Filter passes only runs of three cycles or more
    always_ff @(posedge clk_i)
        filt_o <= raw_o && run_q >= 2'h2;
    initial left_q = 4'h0;
endmodule

// ===== tb/cbtf_tb_top.sv
// Testbench: register, timing, routing, wake and interrupt tests
`timescale 1ns/1ns
module cbtf_tb_top;
    logic clk, rst, wr, rd, go, tick, wake, cfgm, irq, raw, filt;
    logic [3:0] addr, len;
    logic [15:0] wdata, rdata;
    logic [7:0] txc, rxc, ev;
    logic [5:0] est;
    logic [2:0] mode;
    cbtf_pkg::cbtf_hit_t hit;
    cbtf_pkg::cbtf_route_t route;
    int fails, checks_done, i;
    logic [35:0] wtab [6] = '{36'h0FFFF00EF, 36'h2FFFF00FF, 36'h3FFFF47FF,
        36'h11234A53C, 36'h4A5A5A5A5, 36'hC12340000};
    logic [15:0] ptab [4] = '{16'hCDEF, 16'h89AB, 16'h4567, 16'h0123};
    cbtf_top u_cbtf_top (.CLOCK_I(clk), .SRST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .TX_ERR_CNT_I(txc), .RX_ERR_CNT_I(rxc), .ERR_STATE_I(est),
        .EVENT_I(ev), .MODE_I(mode), .BUS_ACT_RAW_I(raw),
        .BUS_ACT_FILT_I(filt), .HIT_I(hit), .ROUTE_O(route), .TIMING_O(),
        .TQ_TICK_O(tick), .WAKE_ACT_O(wake), .CONFIG_MODE_O(cfgm),
        .IRQ_O(irq));
    cbtf_node_model u_cbtf_node_model (.clk_i(clk), .go_i(go),
        .len_i(len), .raw_o(raw), .filt_o(filt));
    task automatic stop_test();
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Gap between the second and third quantum ticks
    task automatic tick_gap(input logic [15:0] e);
        int k, t;
        logic [15:0] n;
        k = 0;
        n = 16'h0000;
        for (t = 0; t < 600 && k < 3; t++)
        begin
            @(posedge clk);
            #1 n = (k < 2) ? 16'h0000 : n + 16'h0001;
            k = k + int'(tick === 1'b1);
        end
        chk(n, e);
        if (k < 3)
        begin
            fails++;
            stop_test();
        end
        @(posedge clk);
    endtask
    // Glitch or long run from the remote node
    task automatic wake_try(input logic [3:0] l, input logic e);
        logic seen;
        seen = 1'b0;
        go <= 1'b1;
        len <= l;
        @(posedge clk);
        go <= 1'b0;
        repeat (10)
        begin
            @(posedge clk);
            #1 seen = seen | (wake === 1'b1);
        end
        chk(seen, e);
        @(posedge clk);
    endtask
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        {rst, wr, rd, go, addr, len, wdata, est, ev, hit} = '0;
        rst = 1'b1;
        {txc, rxc, mode} = {8'hA5, 8'h3C, 3'h4};
        {fails, checks_done} = '0;
        idle(4);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'h4, 16'hFFFF);
        for (i = 2; i < 9; i += (i == 2) ? 3 : 1)
            rd_chk(i[3:0], 16'h0000);
        foreach (wtab[k])
        begin
            wr_reg(wtab[k][35:32], wtab[k][31:16]);
            rd_chk(wtab[k][35:32], wtab[k][15:0]);
        end
        tick_gap(16'd128);
        foreach (ptab[k])
        begin
            wr_reg(4'h5 + k[3:0], ptab[k]);
            rd_chk(4'h5 + k[3:0], ptab[k]);
        end
        for (i = 0; i < 8; i++)
        begin
            wr_reg(4'h2, {8'h00, i[1:0], 6'h00});
            wr_reg(4'h3, {1'b0, i[0], 3'h0, i[2:0], i[1], i[0], {2{i[2:0]}}});
            idle(4);
        end
        tick_gap(16'd2);
        for (i = 0; i < 16; i++)
        begin
            hit <= {1'b1, i[3:0]};
            @(posedge clk);
            hit <= '0;
            #1 chk(route.valid, 16'hA5A5 >> i & 16'h1);
            if (route.valid === 1'b1)
                chk({route.to_fifo, route.to_fifo ? 4'h0 : route.buffer},
                    i == 0 ? 16'h0010 : 16'h000F - i[15:0]);
            @(posedge clk);
        end
        wake_try(4'h1, 1'b0);
        wake_try(4'h6, 1'b1);
        wr_reg(4'h3, 16'h0000);
        wake_try(4'h1, 1'b1);
        mode <= 3'h0;
        idle(3);
        chk(cfgm, 16'h0000);
        est <= 6'h01;
        idle(5);
        chk(irq, 16'h0001);
        rd_chk(4'h9, 16'h0120);
        est <= 6'h00;
        idle(3);
        wr_reg(4'h9, 16'h0000);
        rd_chk(4'h9, 16'h0000);
        chk(irq, 16'h0000);
        wr_reg(4'h0, 16'h0000);
        ev <= 8'h01;
        @(posedge clk);
        ev <= 8'h00;
        idle(5);
        chk(irq, 16'h0000);
        rd_chk(4'h9, 16'h0001);
        wr_reg(4'h0, 16'h0001);
        idle(3);
        chk(irq, 16'h0001);
        stop_test();
    end
endmodule
